// >>> arfs_regs.svh
// register offsets, reset values and timing counts of the restart sequencer
`ifndef ARFS_REGS_SVH
`define ARFS_REGS_SVH
// register byte offsets
`define ARFS_ADDR_MODE    8'h00
`define ARFS_ADDR_COUNT   8'h04
`define ARFS_ADDR_WAIT    8'h08
`define ARFS_ADDR_MON     8'h0c
`define ARFS_ADDR_STAT    8'h10
// restart mode selector codes
`define ARFS_MODE_OFF     3'h0
`define ARFS_MODE_ACK     3'h1
`define ARFS_MODE_PWR     3'h4
`define ARFS_MODE_ANY     3'h6
// reset values
`define ARFS_MODE_RST     3'h0
`define ARFS_COUNT_RST    8'h03
`define ARFS_WAIT_RST     8'h01
`define ARFS_MON_RST      8'h3c
`define ARFS_SECS_RST     8'hff
// status field positions
`define ARFS_STAT_ABORT   0
`define ARFS_STAT_PWR     1
`define ARFS_STAT_TRIES   8
`define ARFS_STAT_STATE   16
// timing: one second on the timebase, guard of one second
`define ARFS_SEC_NS       1000000000
`define ARFS_CLK_NS       40
`define ARFS_SEC_CYC      (`ARFS_SEC_NS / `ARFS_CLK_NS)
`define ARFS_GUARD_S      9'h001
`endif

// >>> arfs_pkg.sv
// types of the restart sequencer
package arfs_pkg;
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_HOLD, ST_CHECK, ST_MON, ST_ABORT
   } arfs_state_e;
   // register bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } arfs_bus_s;
   // fault indications from the drive
   typedef struct packed {
      logic any;         // some fault is pending
      logic cause;       // cause of a pending fault still present
      logic psu;         // power module supply fault
      logic infeed;      // infeed fault
      logic infeed_used; // infeed object in use
   } arfs_flt_s;
   // whole module state
   typedef struct packed {
      arfs_state_e state;
      logic [2:0]  mode;
      logic [7:0]  count;
      logic [7:0]  wait_s;
      logic [7:0]  mon_s;
      logic [31:0] tick;
      logic [7:0]  secs;
      logic [7:0]  tries;
      logic        run_seen;
      logic        pwr_evt;
      logic        ack;
      logic        restart;
      logic        aborted;
      logic [31:0] rdata;
   } arfs_st_s;
endpackage : arfs_pkg

// >>> arfs_seq.sv
// automatic fault acknowledge and restart sequencer
// Function
// - mode zero disables all automatic action
// - mode one acknowledges cleared faults, no restart
// - mode one keeps acknowledging later faults
// - run high: wait time plus one second spacing
// - run low: one second spacing
// - mode one never raises restart aborted
// - mode four restarts on supply faults only
// - mode four ignores other faults, aborts on failure
// - control supply loss counts as power failure
// - mode six restarts after any fault
// - mode six attempts limited by count
// - mode six monitors supply recovery time
// - modes four and six restart without new command
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "arfs_regs.svh"
module arfs_seq #(
   parameter int unsigned SEC_CYCLES = `ARFS_SEC_CYC // cycles per second
) (
   input  wire logic               clock_in,
   input  wire logic               arst_n_in,
   input  wire arfs_pkg::arfs_bus_s bus_in,
   output logic [31:0]             rdata_out,
   input  wire arfs_pkg::arfs_flt_s flt_in,
   input  wire logic [1:0]         trig_in,
   input  wire logic               run_cmd_in,
   input  wire logic               cu_supply_ok_in,
   output logic                    ack_out,
   output logic                    restart_out,
   output logic                    aborted_out
);
   import arfs_pkg::*;

   arfs_st_s q;                      // registered state
   arfs_st_s d;                      // next state
   logic     sec_pulse;              // one second elapsed on timebase
   logic [8:0] guard_s;              // spacing needed in mode one
   logic     mode_wr;                // software writes the mode
   logic     evt_pwr;                // power failure style event
   logic     evt_any;                // fault pending or trigger bit zero
   logic     exhausted;              // attempt count used up

   // elapsed seconds reached a limit
   function automatic logic secs_ge(input logic [7:0] s,
                                    input logic [8:0] lim);
      secs_ge = ({1'b0, s} >= lim);
   endfunction : secs_ge

   ////////////////////////////////////////////////////////////////////
   // event decoding
   ////////////////////////////////////////////////////////////////////
   always_comb begin
      sec_pulse = (q.tick == 32'(SEC_CYCLES - 1));
      mode_wr   = bus_in.wr && (bus_in.addr == `ARFS_ADDR_MODE);
      guard_s   = run_cmd_in ? ({1'b0, q.wait_s} + `ARFS_GUARD_S)
                             : `ARFS_GUARD_S;
      evt_pwr   = !cu_supply_ok_in || flt_in.psu || trig_in[1] ||
                  (flt_in.infeed_used && flt_in.infeed);
      evt_any   = flt_in.any || trig_in[0];
      exhausted = ({1'b0, q.tries} + 9'h001) >= {1'b0, q.count};
   end

   ////////////////////////////////////////////////////////////////////
   // next state
   ////////////////////////////////////////////////////////////////////
   always_comb begin
      d         = q;
      d.ack     = 1'b0;
      d.restart = 1'b0;
      d.rdata   = 32'h0;
      // one second timebase, seconds saturate
      if (sec_pulse) begin
         d.tick = 32'h0;
         if (q.secs != 8'hff) begin
            d.secs = q.secs + 8'h01;
         end
      end else begin
         d.tick = q.tick + 32'h1;
      end
      // sequencer
      unique case (q.state)
         ST_IDLE: begin
            unique case (q.mode)
               `ARFS_MODE_ACK: begin
                  if (flt_in.any && !flt_in.cause &&
                      secs_ge(q.secs, guard_s)) begin
                     d.ack  = 1'b1;
                     d.secs = 8'h00;
                     d.tick = 32'h0;
                  end
               end
               `ARFS_MODE_PWR: begin
                  if (evt_pwr) begin
                     d.state    = ST_HOLD;
                     d.pwr_evt  = 1'b1;
                     d.run_seen = run_cmd_in;
                     d.secs     = 8'h00;
                     d.tick     = 32'h0;
                  end
               end
               `ARFS_MODE_ANY: begin
                  if (evt_any || evt_pwr) begin
                     d.state    = ST_HOLD;
                     d.pwr_evt  = evt_pwr;
                     d.run_seen = run_cmd_in;
                     d.secs     = 8'h00;
                     d.tick     = 32'h0;
                  end
               end
               default: begin
                  d.state = ST_IDLE;
               end
            endcase
         end
         ST_HOLD: begin
            if (cu_supply_ok_in && !flt_in.cause &&
                (q.mode != `ARFS_MODE_ANY ||
                 secs_ge(q.secs, {1'b0, q.wait_s}))) begin
               d.ack   = 1'b1;
               d.state = ST_CHECK;
            end else if (q.mode == `ARFS_MODE_ANY && !cu_supply_ok_in &&
                         secs_ge(q.secs, {1'b0, q.mon_s})) begin
               d.state = ST_ABORT;
            end
         end
         ST_CHECK: begin
            if (flt_in.any) begin
               if (q.mode == `ARFS_MODE_PWR || exhausted) begin
                  d.state = ST_ABORT;
               end else begin
                  d.tries = q.tries + 8'h01;
                  d.state = ST_HOLD;
                  d.secs  = 8'h00;
                  d.tick  = 32'h0;
               end
            end else begin
               d.restart = q.run_seen && run_cmd_in;
               d.state   = ST_MON;
               d.secs    = 8'h00;
               d.tick    = 32'h0;
            end
         end
         ST_MON: begin
            if (q.mode == `ARFS_MODE_ANY && evt_any) begin
               if (exhausted) begin
                  d.state = ST_ABORT;
               end else begin
                  d.tries    = q.tries + 8'h01;
                  d.state    = ST_HOLD;
                  d.run_seen = run_cmd_in;
                  d.secs     = 8'h00;
                  d.tick     = 32'h0;
               end
            end else if (q.mode != `ARFS_MODE_ANY ||
                         secs_ge(q.secs, {1'b0, q.mon_s})) begin
               d.tries   = 8'h00;
               d.pwr_evt = 1'b0;
               d.state   = ST_IDLE;
            end
         end
         ST_ABORT: begin
            // leaves when run command drops
            if (!run_cmd_in) begin
               d.aborted = 1'b0;
               d.tries   = 8'h00;
               d.pwr_evt = 1'b0;
               d.state   = ST_IDLE;
            end
         end
      endcase
      if (d.state == ST_ABORT) begin
         d.aborted = 1'b1;
      end
      // register writes
      if (bus_in.wr) begin
         unique case (bus_in.addr)
            `ARFS_ADDR_MODE: begin
               d.mode    = bus_in.wdata[2:0];
               d.state   = ST_IDLE;
               d.tries   = 8'h00;
               d.aborted = 1'b0;
               d.pwr_evt = 1'b0;
               d.ack     = 1'b0;
               d.restart = 1'b0;
            end
            `ARFS_ADDR_COUNT: d.count  = bus_in.wdata[7:0];
            `ARFS_ADDR_WAIT:  d.wait_s = bus_in.wdata[7:0];
            `ARFS_ADDR_MON:   d.mon_s  = bus_in.wdata[7:0];
            default:          d.count  = q.count;
         endcase
      end
      // register reads, data next cycle
      if (bus_in.rd) begin
         unique case (bus_in.addr)
            `ARFS_ADDR_MODE:  d.rdata = {29'h0, q.mode};
            `ARFS_ADDR_COUNT: d.rdata = {24'h0, q.count};
            `ARFS_ADDR_WAIT:  d.rdata = {24'h0, q.wait_s};
            `ARFS_ADDR_MON:   d.rdata = {24'h0, q.mon_s};
            `ARFS_ADDR_STAT: begin
               d.rdata[`ARFS_STAT_ABORT] = q.aborted;
               d.rdata[`ARFS_STAT_PWR]   = q.pwr_evt;
               d.rdata[`ARFS_STAT_TRIES +: 8] = q.tries;
               d.rdata[`ARFS_STAT_STATE +: 3] = q.state;
            end
            default:          d.rdata = 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register
   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q          <= '0;
         q.state    <= ST_IDLE;
         q.mode     <= `ARFS_MODE_RST;
         q.count    <= `ARFS_COUNT_RST;
         q.wait_s   <= `ARFS_WAIT_RST;
         q.mon_s    <= `ARFS_MON_RST;
         q.secs     <= `ARFS_SECS_RST;
      end else begin
         q <= d;
      end
   end

   // outputs come straight from flip-flops
   assign rdata_out   = q.rdata;
   assign ack_out     = q.ack;
   assign restart_out = q.restart;
   assign aborted_out = q.aborted;

   ////////////////////////////////////////////////////////////////////
   // assertions
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);

   AST_OFF_IDLE: assert property (
      q.mode == `ARFS_MODE_OFF |-> q.state == ST_IDLE && !restart_out)
      else $error("sequencer active while disabled");
   AST_ACK_ONE_NO_RESTART: assert property (
      restart_out |-> $past(q.mode) != `ARFS_MODE_ACK)
      else $error("restart issued in acknowledge only mode");
   AST_ACK_CAUSE_CLEAR: assert property (
      ack_out |-> !$past(flt_in.cause))
      else $error("acknowledge while fault cause present");
   AST_ACK_SPACING: assert property (
      ack_out && $past(q.mode) == `ARFS_MODE_ACK |->
      ($past(run_cmd_in) ? {1'b0, $past(q.secs)} > {1'b0, $past(q.wait_s)}
                         : $past(q.secs) >= 8'h01))
      else $error("acknowledge spacing violated");
   AST_ACK_ONE_NO_ABORT: assert property (
      q.mode == `ARFS_MODE_ACK |-> !aborted_out)
      else $error("restart aborted raised in mode one");
   AST_PWR_TRIGGER: assert property (
      q.state == ST_IDLE && q.mode == `ARFS_MODE_PWR && !cu_supply_ok_in
      && !bus_in.wr |=> q.state == ST_HOLD ##1 !ack_out)
      else $error("control supply loss not taken as power failure");
   AST_PWR_ACK_FAIL: assert property (
      q.state == ST_CHECK && q.mode == `ARFS_MODE_PWR && flt_in.any
      && !bus_in.wr |=> aborted_out && !restart_out)
      else $error("failed acknowledge did not abort");
   AST_ANY_TRIGGER: assert property (
      q.state == ST_IDLE && q.mode == `ARFS_MODE_ANY && trig_in[0]
      && !bus_in.wr |=> q.state == ST_HOLD)
      else $error("trigger bit zero ignored in mode six");
   AST_MON_TIMEOUT: assert property (
      q.state == ST_HOLD && q.mode == `ARFS_MODE_ANY && !cu_supply_ok_in
      && q.secs >= q.mon_s && !bus_in.wr |=> aborted_out)
      else $error("supply recovery timeout not flagged");
   AST_RESTART_RUN: assert property (
      restart_out |-> $past(run_cmd_in) && $past(q.run_seen))
      else $error("restart without run command");
   AST_CLEAR_TRIES: assert property (
      q.state == ST_MON && q.mode == `ARFS_MODE_ANY && !evt_any
      && q.secs >= q.mon_s && !bus_in.wr |=> q.tries == 8'h00)
      else $error("attempt counter not cleared");

   COV_ACK_ONE: cover property (q.mode == `ARFS_MODE_ACK && ack_out);
   COV_PWR_RESTART: cover property (q.mode == `ARFS_MODE_PWR
                                    && restart_out);
   COV_ANY_RETRY: cover property (q.state == ST_CHECK ##1
                                  q.state == ST_HOLD && q.tries != 8'h00);
   COV_ABORT: cover property ($rose(aborted_out));
endmodule : arfs_seq

// >>> arfs_plc_model.sv
// operator or controller model: parameters, reads and run command
`timescale 1ns/1ps
`include "arfs_regs.svh"
module arfs_plc_model (
   input  wire logic           clock_in,
   input  wire logic [31:0]    rdata_in,
   output arfs_pkg::arfs_bus_s bus_out,
   output logic                run_cmd_out
);
   import arfs_pkg::*;
   // idle bus and run command low from time zero
   initial begin
      bus_out = '0;
      run_cmd_out = 1'b0;
   end
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock_in);
      bus_out <= '0;
   endtask : wr
   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_in);
      bus_out <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clock_in);
      bus_out <= '0;
      #1;
      d = rdata_in;
   endtask : rd
   task automatic configure(input logic [2:0] m, input logic [7:0] c,
                            input logic [7:0] w, input logic [7:0] t);
      wr(`ARFS_ADDR_MODE, {29'h0, m});
      wr(`ARFS_ADDR_COUNT, {24'h0, c});
      wr(`ARFS_ADDR_WAIT, {24'h0, w});
      wr(`ARFS_ADDR_MON, {24'h0, t});
   endtask : configure
   // run level held across supply loss
   task automatic set_run(input logic v);
      @(posedge clock_in);
      run_cmd_out <= v;
   endtask : set_run
endmodule : arfs_plc_model

// >>> test_arfs_seq.sv
// self-checking bench of the restart sequencer
`timescale 1ns/1ps
`include "arfs_regs.svh"
module test_arfs_seq;
   import arfs_pkg::*;
   logic        clock_in = 1'b0;
   logic        arst_n_in = 1'b0;
   arfs_bus_s   bus;
   logic [31:0] rdata;
   arfs_flt_s   flt = '0;   // bit order: any cause psu infeed used
   logic [1:0]  trig = 2'h0;
   logic        run;
   logic        sup = 1'b1;
   logic        ack, restart, aborted;
   logic [31:0] d;
   int          n_errors = 0;
   int          num_checks = 0;
   int          bad = 0;
   logic        m1 = 1'b0;
   always #20 clock_in = ~clock_in;
   // mode one must never restart or abort
   always @(posedge clock_in) if (m1 && (restart || aborted)) bad++;
   arfs_seq #(.SEC_CYCLES(10)) u_arfs_seq (
      .clock_in(clock_in), .arst_n_in(arst_n_in), .bus_in(bus),
      .rdata_out(rdata), .flt_in(flt), .trig_in(trig),
      .run_cmd_in(run), .cu_supply_ok_in(sup), .ack_out(ack),
      .restart_out(restart), .aborted_out(aborted));
   arfs_plc_model u_arfs_plc_model (
      .clock_in(clock_in), .rdata_in(rdata), .bus_out(bus),
      .run_cmd_out(run));
   task automatic summarize();
      if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   task automatic check(input string nm, input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
      end
   endtask : check
   function automatic int sel(input int w);
      return int'((w == 0 ? ack : w == 1 ? restart : aborted) === 1'b1);
   endfunction : sel
   // bounded wait for an output, a miss ends the run
   task automatic await(input int w, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge clock_in);
         #1;
         n++;
      end while (sel(w) == 0 && n < lim);
      if (sel(w) == 0) begin
         check("await", w, 32'hff);
         summarize();
      end
   endtask : await
   // number of cycles an output is high in a window
   task automatic hits(input int w, input int len, output int h);
      h = 0;
      repeat (len) begin
         @(posedge clock_in);
         #1;
         h += sel(w);
      end
   endtask : hits
   task automatic idle();
      @(posedge clock_in);
      flt <= '0;
      trig <= 2'h0;
      sup <= 1'b1;
      u_arfs_plc_model.set_run(1'b0);
      u_arfs_plc_model.wr(`ARFS_ADDR_MODE, 32'h0);
   endtask : idle
   // supply style fault in mode four: acknowledge, then restart
   task automatic pwr_flt(input logic [4:0] f, input string nm);
      flt <= f;
      await(0, 10);
      flt <= '0;
      @(posedge clock_in);
      #1;
      check(nm, restart, 1'b1);
   endtask : pwr_flt
   task automatic t_regs();
      u_arfs_plc_model.rd(`ARFS_ADDR_MODE, d);
      check("mode", d, 32'h0);
      u_arfs_plc_model.rd(`ARFS_ADDR_COUNT, d);
      check("count", d, 32'h3);
      u_arfs_plc_model.rd(`ARFS_ADDR_MON, d);
      check("mon", d, 32'h3c);
      // upper write bits are dropped, wait stays at its reset value
      u_arfs_plc_model.wr(`ARFS_ADDR_WAIT, 32'hffff_ff01);
      u_arfs_plc_model.rd(`ARFS_ADDR_WAIT, d);
      check("wait", d, 32'h1);
      u_arfs_plc_model.rd(8'h14, d);
      check("unmapped", d, 32'h0);
   endtask : t_regs
   task automatic t_off();
      int h;
      @(posedge clock_in);
      flt <= 5'b10000;
      sup <= 1'b0;
      trig <= 2'h3;
      hits(0, 40, h);
      check("off ack", h, 0);
      // an unassigned mode code behaves as off
      u_arfs_plc_model.wr(`ARFS_ADDR_MODE, 32'h2);
      hits(0, 20, h);
      check("odd mode ack", h, 0);
      idle();
      hits(1, 20, h);
      check("off restart", h, 0);
   endtask : t_off
   task automatic t_ack();
      int h;
      u_arfs_plc_model.wr(`ARFS_ADDR_MODE, 32'h1);
      m1 = 1'b1;
      @(posedge clock_in);
      flt <= 5'b11000;
      hits(0, 20, h);
      check("cause held", h, 0);
      flt <= 5'b10000;
      await(0, 5);
      flt <= 5'b10000;
      hits(0, 8, h);
      check("run low gap", h, 0);
      await(0, 30);
      u_arfs_plc_model.set_run(1'b1);
      hits(0, 17, h);
      check("run high gap", h, 0);
      await(0, 30);
      idle();
      m1 = 1'b0;
      check("mode1 quiet", bad, 0);
   endtask : t_ack
   task automatic t_pwr();
      int h;
      u_arfs_plc_model.configure(`ARFS_MODE_PWR, 8'h3, 8'h1, 8'h3c);
      u_arfs_plc_model.set_run(1'b1);
      @(posedge clock_in);
      sup <= 1'b0;
      repeat (4) @(posedge clock_in);
      sup <= 1'b1;
      flt <= 5'b10000;
      @(posedge clock_in);
      flt <= '0;
      #1;
      check("pwr ack", ack, 1'b1);
      @(posedge clock_in);
      #1;
      check("pwr restart", restart, 1'b1);
      @(posedge clock_in);
      sup <= 1'b0;
      repeat (4) @(posedge clock_in);
      sup <= 1'b1;
      flt <= 5'b10000;
      await(2, 10);
      hits(2, 3, h);
      check("abort holds", h, 3);
      u_arfs_plc_model.set_run(1'b0);
      flt <= '0;
      hits(2, 3, h);
      check("abort cleared", aborted, 1'b0);
      @(posedge clock_in);
      sup <= 1'b0;
      repeat (4) @(posedge clock_in);
      sup <= 1'b1;
      hits(1, 30, h);
      check("no run", h, 0);
      u_arfs_plc_model.set_run(1'b1);
      @(posedge clock_in);
      trig <= 2'h1;
      @(posedge clock_in);
      trig <= 2'h0;
      hits(0, 30, h);
      check("bit0 in mode4", h, 0);
      trig <= 2'h2;
      @(posedge clock_in);
      trig <= 2'h0;
      await(0, 10);
      @(posedge clock_in);
      #1;
      check("trig restart", restart, 1'b1);
      // infeed fault counts only with the infeed object in use
      flt <= 5'b10010;
      hits(0, 20, h);
      check("infeed unused", h, 0);
      pwr_flt(5'b10011, "infeed restart");
      pwr_flt(5'b10100, "psu restart");
      idle();
   endtask : t_pwr
   task automatic t_any();
      int h;
      u_arfs_plc_model.configure(`ARFS_MODE_ANY, 8'h2, 8'h1, 8'h2);
      u_arfs_plc_model.set_run(1'b1);
      @(posedge clock_in);
      flt <= 5'b10000;
      h = 0;
      for (int i = 0; i < 300 && aborted !== 1'b1; i++) begin
         @(posedge clock_in);
         #1;
         h += sel(0);
      end
      check("attempts", h, 2);
      check("any abort", aborted, 1'b1);
      idle();
      u_arfs_plc_model.configure(`ARFS_MODE_ANY, 8'h3, 8'h1, 8'h2);
      u_arfs_plc_model.set_run(1'b1);
      @(posedge clock_in);
      trig <= 2'h1;
      @(posedge clock_in);
      trig <= 2'h0;
      await(0, 60);
      @(posedge clock_in);
      #1;
      check("trig restart", restart, 1'b1);
      repeat (60) @(posedge clock_in);
      flt <= 5'b10000;
      await(0, 60);
      @(posedge clock_in);
      flt <= '0;
      await(0, 60);
      @(posedge clock_in);
      #1;
      check("retry restart", restart, 1'b1);
      // one retry counted while the restart is monitored
      u_arfs_plc_model.rd(`ARFS_ADDR_STAT, d);
      check("tries held", d[18:8], 11'h301);
      repeat (60) @(posedge clock_in);
      u_arfs_plc_model.rd(`ARFS_ADDR_STAT, d);
      check("tries", d[18:8], 11'h0);
      sup <= 1'b0;
      hits(2, 12, h);
      check("mon early", h, 0);
      await(2, 60);
      idle();
   endtask : t_any
   initial begin
      repeat (4) @(posedge clock_in);
      arst_n_in <= 1'b1;
      t_regs();
      t_off();
      t_ack();
      t_pwr();
      t_any();
      summarize();
   end
endmodule : test_arfs_seq
